// ### iplr_top.sv
// Interrupt priority level registers with APB slave and decoded levels
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
`include "iplr_params.svh"

// Behaviour
// - Debug sources decode 00 off, 01 level 1, 10 level 2, 11 level 3
// - Other sources decode 00 off, 01 level 0, 10 level 1, 11 level 2
// - Reset clears every field to 00; all registers read zero
// - Debug event register bits 13:12 hold breakpoint unit 0 field
// - Debug event register bits 11:10 hold step counter field
// - Reserved bits read zero and ignore writes
// - Offset 1 bits 5:4 hold debug receive-full field
// - Offset 1 bits 3:2 hold debug transmit-empty field
// - Offset 1 bits 1:0 hold trace buffer field
// - Offset 2 bits 15:14 hold flash buffers empty field
// - Offset 2 bits 13:12 hold flash command complete field
// - Offset 2 bits 11:10 hold flash error field
// - Offset 2 bits 9:8 hold PLL loss-of-lock field
// - Offset 2 bits 7:6 hold low-voltage field
// - Offset 2 bits 3:2 hold external pin B field
// - Offset 2 bits 1:0 hold external pin A field
// - Offset 3 top fields hold ports D, E, F downward
// - Offset 3 bits 9:8 hold CAN message buffer field
// - Offset 3 bits 7:6 hold CAN wake-up field
// - Offset 3 bits 5:4 hold CAN error field, levels 0 to 2
// - Offset 3 bits 3:2 hold CAN bus-off field; bits 1:0 reserved
module iplr_top #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic [`IPLR_NUM_SRC-1:0] src_enable,
    output logic [2*`IPLR_NUM_SRC-1:0] src_level
);
    import iplr_pkg::*;

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    function automatic logic addr_ok(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'h0) && ((a >> 2) < ADDR_W'(`IPLR_NUM_REGS));
    endfunction

    function automatic logic [15:0] reg_mask(input logic [1:0] idx);
        logic [15:0] m;
        m = `IPLR_DEBUG_EVENT_MASK;
        if (idx == `IPLR_DEBUG_DATA_IDX) begin
            m = `IPLR_DEBUG_DATA_MASK;
        end else if (idx == `IPLR_SYSTEM_IDX) begin
            m = `IPLR_SYSTEM_MASK;
        end else if (idx == `IPLR_PORT_CAN_IDX) begin
            m = `IPLR_PORT_CAN_MASK;
        end
        return m;
    endfunction

    // Debug sources run one level higher than the rest
    function automatic logic [1:0] decode_level(input iplr_priority_level_field_t f,
                                                input logic debug_src);
        logic [1:0] lvl;
        lvl = 2'h0;
        if (f != `IPLR_FIELD_DISABLED) begin
            lvl = debug_src ? f : 2'(f - 2'h1);
        end
        return lvl;
    endfunction

    // Enable rides above the level, so one flop holds a whole source
    function automatic logic [2:0] decode_out(input iplr_priority_level_field_t f,
                                              input logic debug_src);
        return {f != `IPLR_FIELD_DISABLED, decode_level(f, debug_src)};
    endfunction

    // ----------------------------------------
    // Register storage
    // ----------------------------------------
    logic [15:0] prio_reg [4];
    logic [15:0] prio_next;
    logic [1:0] widx;
    logic wr_access;
    logic rd_setup;
    logic setup;

    assign setup = psel && !penable;
    assign widx = paddr[3:2];
    assign wr_access = psel && penable && pready && pwrite && addr_ok(paddr);

    always_comb begin
        prio_next = prio_reg[widx];
        if (pstrb[0]) begin
            prio_next[7:0] = pwdata[7:0];
        end
        if (pstrb[1]) begin
            prio_next[15:8] = pwdata[15:8];
        end
        prio_next = prio_next & reg_mask(widx);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            for (int i = 0; i < 4; i++) begin
                prio_reg[i] <= `IPLR_RESET_VAL;
            end
        end else if (wr_access) begin
            prio_reg[widx] <= prio_next;
        end
    end

    // ----------------------------------------
    // APB answer: no wait states, all outputs registered
    // ----------------------------------------
    assign rd_setup = setup && !pwrite && addr_ok(paddr);

    always_ff @(posedge mclk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !addr_ok(paddr);
        end
    end

    // Read data sampled at setup; reserved bits are stored as zero
    always_ff @(posedge mclk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata <= {16'h0000, prio_reg[widx]};
        end else if (setup) begin
            prdata <= 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Field extraction
    // ----------------------------------------
    iplr_priority_level_field_t fld [`IPLR_NUM_SRC];

    always_comb begin
        fld[breakpoint0_level] =
            prio_reg[`IPLR_DEBUG_EVENT_IDX][`IPLR_BREAKPOINT0_LSB+:2];
        fld[step_counter_level] =
            prio_reg[`IPLR_DEBUG_EVENT_IDX][`IPLR_STEP_COUNTER_LSB+:2];
        fld[debug_rx_full_level] =
            prio_reg[`IPLR_DEBUG_DATA_IDX][`IPLR_DEBUG_RX_FULL_LSB+:2];
        fld[debug_tx_empty_level] =
            prio_reg[`IPLR_DEBUG_DATA_IDX][`IPLR_DEBUG_TX_EMPTY_LSB+:2];
        fld[trace_buffer_level] =
            prio_reg[`IPLR_DEBUG_DATA_IDX][`IPLR_TRACE_BUFFER_LSB+:2];
        fld[flash_buffers_empty_level] =
            prio_reg[`IPLR_SYSTEM_IDX][`IPLR_FLASH_BUFFERS_EMPTY_LSB+:2];
        fld[flash_cmd_done_level] =
            prio_reg[`IPLR_SYSTEM_IDX][`IPLR_FLASH_CMD_DONE_LSB+:2];
        fld[flash_error_level] =
            prio_reg[`IPLR_SYSTEM_IDX][`IPLR_FLASH_ERROR_LSB+:2];
        fld[pll_unlock_level] =
            prio_reg[`IPLR_SYSTEM_IDX][`IPLR_PLL_UNLOCK_LSB+:2];
        fld[low_voltage_level] =
            prio_reg[`IPLR_SYSTEM_IDX][`IPLR_LOW_VOLTAGE_LSB+:2];
        fld[ext_pin_b_level] =
            prio_reg[`IPLR_SYSTEM_IDX][`IPLR_EXT_PIN_B_LSB+:2];
        fld[ext_pin_a_level] =
            prio_reg[`IPLR_SYSTEM_IDX][`IPLR_EXT_PIN_A_LSB+:2];
        fld[port_d_level] =
            prio_reg[`IPLR_PORT_CAN_IDX][`IPLR_PORT_D_LSB+:2];
        fld[port_e_level] =
            prio_reg[`IPLR_PORT_CAN_IDX][`IPLR_PORT_E_LSB+:2];
        fld[port_f_level] =
            prio_reg[`IPLR_PORT_CAN_IDX][`IPLR_PORT_F_LSB+:2];
        fld[can_msgbuf_level] =
            prio_reg[`IPLR_PORT_CAN_IDX][`IPLR_CAN_MSGBUF_LSB+:2];
        fld[can_wakeup_level] =
            prio_reg[`IPLR_PORT_CAN_IDX][`IPLR_CAN_WAKEUP_LSB+:2];
        fld[can_error_level] =
            prio_reg[`IPLR_PORT_CAN_IDX][`IPLR_CAN_ERROR_LSB+:2];
        fld[can_busoff_level] =
            prio_reg[`IPLR_PORT_CAN_IDX][`IPLR_CAN_BUSOFF_LSB+:2];
    end

    // ----------------------------------------
    // Decoded levels toward arbitration
    // ----------------------------------------
    // Registered to keep arbitration timing off the bus path; one cycle lag
    logic [2:0] brk0_out_reg;
    logic [2:0] step_out_reg;
    logic [2:0] rxf_out_reg;
    logic [2:0] txe_out_reg;
    logic [2:0] trace_out_reg;
    logic [2:0] fbe_out_reg;
    logic [2:0] fcd_out_reg;
    logic [2:0] ferr_out_reg;
    logic [2:0] pll_out_reg;
    logic [2:0] lvd_out_reg;
    logic [2:0] pinb_out_reg;
    logic [2:0] pina_out_reg;
    logic [2:0] portd_out_reg;
    logic [2:0] porte_out_reg;
    logic [2:0] portf_out_reg;
    logic [2:0] cmsg_out_reg;
    logic [2:0] cwake_out_reg;
    logic [2:0] cerr_out_reg;
    logic [2:0] cboff_out_reg;

    always_ff @(posedge mclk) begin
        if (srst) begin
            brk0_out_reg <= 3'h0;
        end else begin
            brk0_out_reg <= decode_out(fld[breakpoint0_level], 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            step_out_reg <= 3'h0;
        end else begin
            step_out_reg <= decode_out(fld[step_counter_level], 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rxf_out_reg <= 3'h0;
        end else begin
            rxf_out_reg <= decode_out(fld[debug_rx_full_level], 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            txe_out_reg <= 3'h0;
        end else begin
            txe_out_reg <= decode_out(fld[debug_tx_empty_level], 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            trace_out_reg <= 3'h0;
        end else begin
            trace_out_reg <= decode_out(fld[trace_buffer_level], 1'b1);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            fbe_out_reg <= 3'h0;
        end else begin
            fbe_out_reg <= decode_out(fld[flash_buffers_empty_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            fcd_out_reg <= 3'h0;
        end else begin
            fcd_out_reg <= decode_out(fld[flash_cmd_done_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            ferr_out_reg <= 3'h0;
        end else begin
            ferr_out_reg <= decode_out(fld[flash_error_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pll_out_reg <= 3'h0;
        end else begin
            pll_out_reg <= decode_out(fld[pll_unlock_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            lvd_out_reg <= 3'h0;
        end else begin
            lvd_out_reg <= decode_out(fld[low_voltage_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pinb_out_reg <= 3'h0;
        end else begin
            pinb_out_reg <= decode_out(fld[ext_pin_b_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            pina_out_reg <= 3'h0;
        end else begin
            pina_out_reg <= decode_out(fld[ext_pin_a_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            portd_out_reg <= 3'h0;
        end else begin
            portd_out_reg <= decode_out(fld[port_d_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            porte_out_reg <= 3'h0;
        end else begin
            porte_out_reg <= decode_out(fld[port_e_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            portf_out_reg <= 3'h0;
        end else begin
            portf_out_reg <= decode_out(fld[port_f_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cmsg_out_reg <= 3'h0;
        end else begin
            cmsg_out_reg <= decode_out(fld[can_msgbuf_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cwake_out_reg <= 3'h0;
        end else begin
            cwake_out_reg <= decode_out(fld[can_wakeup_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cerr_out_reg <= 3'h0;
        end else begin
            cerr_out_reg <= decode_out(fld[can_error_level], 1'b0);
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            cboff_out_reg <= 3'h0;
        end else begin
            cboff_out_reg <= decode_out(fld[can_busoff_level], 1'b0);
        end
    end

    // Plain wiring of flop bits, source 0 in the least significant place
    assign src_enable = {cboff_out_reg[2], cerr_out_reg[2], cwake_out_reg[2], cmsg_out_reg[2],
        portf_out_reg[2], porte_out_reg[2], portd_out_reg[2], pina_out_reg[2],
        pinb_out_reg[2], lvd_out_reg[2], pll_out_reg[2], ferr_out_reg[2],
        fcd_out_reg[2], fbe_out_reg[2], trace_out_reg[2], txe_out_reg[2],
        rxf_out_reg[2], step_out_reg[2], brk0_out_reg[2]};
    assign src_level = {cboff_out_reg[1:0], cerr_out_reg[1:0], cwake_out_reg[1:0],
        cmsg_out_reg[1:0], portf_out_reg[1:0], porte_out_reg[1:0], portd_out_reg[1:0],
        pina_out_reg[1:0], pinb_out_reg[1:0], lvd_out_reg[1:0], pll_out_reg[1:0],
        ferr_out_reg[1:0], fcd_out_reg[1:0], fbe_out_reg[1:0], trace_out_reg[1:0],
        txe_out_reg[1:0], rxf_out_reg[1:0], step_out_reg[1:0], brk0_out_reg[1:0]};

endmodule

// ### iplr_params.svh
// Register map constants for the interrupt priority level registers
`ifndef IPLR_PARAMS_SVH
`define IPLR_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IPLR_DEBUG_EVENT_IDX 2'h0
`define IPLR_DEBUG_DATA_IDX 2'h1
`define IPLR_SYSTEM_IDX 2'h2
`define IPLR_PORT_CAN_IDX 2'h3
`define IPLR_NUM_REGS 3'h4

// ----------------------------------------
// Reset values and writable masks
// ----------------------------------------
`define IPLR_RESET_VAL 16'h0000
`define IPLR_DEBUG_EVENT_MASK 16'h3C00
`define IPLR_DEBUG_DATA_MASK 16'h003F
`define IPLR_SYSTEM_MASK 16'hFFCF
`define IPLR_PORT_CAN_MASK 16'hFFFC

// ----------------------------------------
// Field least significant bit positions
// ----------------------------------------
`define IPLR_BREAKPOINT0_LSB 12
`define IPLR_STEP_COUNTER_LSB 10
`define IPLR_DEBUG_RX_FULL_LSB 4
`define IPLR_DEBUG_TX_EMPTY_LSB 2
`define IPLR_TRACE_BUFFER_LSB 0
`define IPLR_FLASH_BUFFERS_EMPTY_LSB 14
`define IPLR_FLASH_CMD_DONE_LSB 12
`define IPLR_FLASH_ERROR_LSB 10
`define IPLR_PLL_UNLOCK_LSB 8
`define IPLR_LOW_VOLTAGE_LSB 6
`define IPLR_EXT_PIN_B_LSB 2
`define IPLR_EXT_PIN_A_LSB 0
`define IPLR_PORT_D_LSB 14
`define IPLR_PORT_E_LSB 12
`define IPLR_PORT_F_LSB 10
`define IPLR_CAN_MSGBUF_LSB 8
`define IPLR_CAN_WAKEUP_LSB 6
`define IPLR_CAN_ERROR_LSB 4
`define IPLR_CAN_BUSOFF_LSB 2

// ----------------------------------------
// Field encodings
// ----------------------------------------
`define IPLR_FIELD_DISABLED 2'h0
`define IPLR_NUM_SRC 19
`define IPLR_NUM_DEBUG_SRC 5

`endif

// ### iplr_pkg.sv
// Types shared by the interrupt priority level registers
package iplr_pkg;

    // ----------------------------------------
    // Source order on the level outputs
    // ----------------------------------------
    typedef enum logic [4:0] {
        breakpoint0_level = 5'h00,
        step_counter_level = 5'h01,
        debug_rx_full_level = 5'h02,
        debug_tx_empty_level = 5'h03,
        trace_buffer_level = 5'h04,
        flash_buffers_empty_level = 5'h05,
        flash_cmd_done_level = 5'h06,
        flash_error_level = 5'h07,
        pll_unlock_level = 5'h08,
        low_voltage_level = 5'h09,
        ext_pin_b_level = 5'h0A,
        ext_pin_a_level = 5'h0B,
        port_d_level = 5'h0C,
        port_e_level = 5'h0D,
        port_f_level = 5'h0E,
        can_msgbuf_level = 5'h0F,
        can_wakeup_level = 5'h10,
        can_error_level = 5'h11,
        can_busoff_level = 5'h12
    } iplr_src_t;

    typedef logic [1:0] iplr_priority_level_field_t;

endpackage

// ### iplr_monitor.sv
// Checker for the priority level registers
`timescale 1ns/1ps
module iplr_monitor #(
    parameter int ADDR_W = 12
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [18:0] src_enable,
    input wire logic [37:0] src_level
);
    logic [15:0] rm;
    logic [18:0] nz, l3;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    always_comb begin
        rm = paddr[3] ? (paddr[2] ? 16'hFFFC : 16'hFFCF) : (paddr[2] ? 16'h003F : 16'h3C00);
        for (int s = 0; s < 19; s++) begin
            nz[s] = |src_level[2*s+:2];
            l3[s] = &src_level[2*s+:2];
        end
    end
    property p_rdy;
        psel && !penable |=> pready;
    endproperty
    a_rdy: assert property (p_rdy) else $error("no ready");
    property p_err;
        pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr[ADDR_W-1:4] != '0);
    endproperty
    a_err: assert property (p_err) else $error("bad slverr");
    property p_res;
        pready && !pwrite |-> (prdata & ~{16'h0, rm}) == 32'h0;
    endproperty
    a_res: assert property (p_res) else $error("reserved bits set");
    property p_rst;
        $fell(srst) |-> src_enable == '0 && src_level == '0 && prdata == '0;
    endproperty
    a_rst: assert property (p_rst) else $error("not cleared");
    property p_dis;
        (nz & ~src_enable) == 19'h0 && nz[4:0] == src_enable[4:0];
    endproperty
    a_dis: assert property (p_dis) else $error("level on disabled");
    property p_l3;
        l3[18:5] == 14'h0;
    endproperty
    a_l3: assert property (p_l3) else $error("level 3 on plain source");
    // Levels lag the register by one flop, hence two edges
    property p_wa;
        pready && pwrite && !pslverr && paddr[3:2] == 2'h2 && pstrb[0] |-> ##2
            src_enable[11] == ($past(pwdata[1:0], 2) != 2'h0) &&
            (!src_enable[11] || src_level[23:22] == $past(pwdata[1:0], 2) - 2'h1);
    endproperty
    a_wa: assert property (p_wa) else $error("pin A level");
    property p_wb;
        pready && pwrite && !pslverr && paddr[3:2] == 2'h0 && pstrb[1] |-> ##2
            src_level[3:0] == {$past(pwdata[11:10], 2), $past(pwdata[13:12], 2)};
    endproperty
    a_wb: assert property (p_wb) else $error("debug levels");
endmodule
bind iplr_top iplr_monitor #(.ADDR_W(ADDR_W)) u_mon (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .src_enable(src_enable),
    .src_level(src_level));

// ### iplr_arb_model.sv
// Arbitration side model: highest enabled level
`timescale 1ns/1ps
module iplr_arb_model (
    input wire logic [18:0] src_enable,
    input wire logic [37:0] src_level,
    output logic any_req,
    output logic [1:0] top_level
);
    always_comb begin
        any_req = |src_enable;
        top_level = 2'h0;
        for (int s = 0; s < 19; s++) begin
            if (src_enable[s] && src_level[2*s+:2] > top_level) top_level = src_level[2*s+:2];
        end
    end
endmodule

// ### tb_top.sv
// Random and corner tests of the priority level registers
`timescale 1ns/1ps
module tb_top;
    logic mclk, srst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic pready, pslverr, err, any_req;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [3:0] pstrb = 4'h0;
    logic [18:0] src_enable;
    logic [37:0] src_level;
    logic [1:0] top_level;
    logic [15:0] seed = 16'h0006, t, sh [4] = '{default: 16'h0};
    int errors, tests_run, cyc;
    localparam logic [15:0] MSK [4] = '{16'h3C00, 16'h003F, 16'hFFCF, 16'hFFFC};
    localparam logic [15:0] PAT [4] = '{16'hFFFF, 16'h5555, 16'hAAAA, 16'h0000};
    localparam int LSB [19] = '{12, 10, 4, 2, 0,
        14, 12, 10, 8, 6, 2, 0,
        14, 12, 10, 8, 6, 4, 2};
    iplr_top uut (.mclk(mclk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .src_enable(src_enable), .src_level(src_level));
    iplr_arb_model u_arb (.src_enable(src_enable), .src_level(src_level),
        .any_req(any_req), .top_level(top_level));
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            give_verdict();
        end
    end
    function automatic logic [15:0] lf(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [59:0] expect_src();
        logic [1:0] f;
        logic [59:0] r;
        r = '0;
        for (int s = 0; s < 19; s++) begin
            f = sh[(s < 2) ? 0 : (s < 5) ? 1 : (s < 12) ? 2 : 3][LSB[s]+:2];
            r[38+s] = f != 2'h0;
            r[2*s+:2] = (f == 2'h0 || s < 5) ? f : f - 2'h1;
            r[57] = r[57] | r[38+s];
            if (r[2*s+:2] > r[59:58]) r[59:58] = r[2*s+:2];
        end
        return r;
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Idle edge first, so back-to-back calls never drive twice in one step
    task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d,
            input logic [3:0] s);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {~d, d};
        pstrb <= s;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [1:0] i);
        apb(1'b0, {8'h0, i, 2'h0}, 16'h0, 4'h0);
        chk({err, rd}, {17'h0, sh[i]});
        chk({top_level, any_req, src_enable, src_level}, expect_src());
    endtask
    task automatic wr(input logic [1:0] i, input logic [15:0] d, input logic [3:0] s);
        apb(1'b1, {8'h0, i, 2'h0}, d, s);
        sh[i] = (sh[i] & ~{{8{s[1]}}, {8{s[0]}}}) | (d & {{8{s[1]}}, {8{s[0]}}} & MSK[i]);
        rdchk(i);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 0; i < 4; i++) rdchk(2'(i));
        $display("reset test done");
        for (int p = 0; p < 4; p++) begin
            for (int i = 0; i < 4; i++) wr(2'(i), PAT[p], 4'hF);
        end
        $display("pattern test done");
        apb(1'b1, 12'h010, 16'hFFFF, 4'hF);
        chk(err, 1'b1);
        apb(1'b0, 12'h00A, 16'h0, 4'h0);
        chk({err, rd}, {1'b1, 32'h0});
        for (int i = 0; i < 4; i++) rdchk(2'(i));
        $display("unmapped test done");
        for (int k = 0; k < 80; k++) begin
            seed = lf(seed);
            t = seed;
            seed = lf(seed);
            wr(t[1:0], seed, t[5:2]);
        end
        $display("random test done");
        @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        sh = '{default: 16'h0};
        for (int i = 0; i < 4; i++) rdchk(2'(i));
        $display("second reset test done");
        give_verdict();
    end
endmodule
